// [design/strap_cfg_pkg.sv]
// Purpose: shared constants and types for the strap configuration block
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes: all offsets are byte addresses
`default_nettype none
package strap_cfg_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STRAP = 8'h04;
    localparam logic [7:0] OFF_PHASE = 8'h08;
    localparam logic [7:0] OFF_OUTPUT_CURRENT_REPORT = 8'h0c;
    localparam logic [7:0] OFF_MAX_CURRENT_SETTING = 8'h10;
    localparam logic [7:0] OFF_CMD = 8'h14;
    localparam logic [7:0] OFF_AVG = 8'h18;
    // ----------------------------------------------------------------
    // codes
    // ----------------------------------------------------------------
    localparam logic [3:0] SVID_ADDR_A = 4'h4;
    localparam logic [3:0] SVID_ADDR_B = 4'h2;
    localparam logic [1:0] COMP_R4K99 = 2'h0;
    localparam logic [1:0] COMP_R14K99 = 2'h1;
    localparam logic [1:0] COMP_R24K99 = 2'h2;
    localparam logic [1:0] COMP_OPEN = 2'h3;
    localparam logic [7:0] PMB_A0 = 8'hee;
    localparam logic [7:0] PMB_A1 = 8'hea;
    localparam logic [7:0] PMB_A2 = 8'he6;
    localparam logic [7:0] PMB_A3 = 8'he2;
    localparam logic [7:0] PMB_B0 = 8'hec;
    localparam logic [7:0] PMB_B1 = 8'he8;
    localparam logic [7:0] PMB_B2 = 8'he4;
    localparam logic [7:0] PMB_B3 = 8'he0;
    localparam logic [7:0] FULL_POWER_STATE = 8'h00;
    localparam logic [7:0] PHASE_THRESH_MA = 8'd12;  // 12 A, in amperes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [2:0] CTRL_LOAD_BIT = 3'd0;
    localparam logic [2:0] CTRL_DPM_BIT = 3'd1;
    localparam logic [31:0] CMD_TARGET_SINGLE = 32'h0000_0001;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOAD = 3'b010,
        ST_RUN = 3'b100
    } cfg_state_t;

    typedef struct packed {
        logic [3:0] svid_addr;
        logic [1:0] comp_sel;
        logic [2:0] phase_hi;     // phase outputs seen pulled high
        logic single_hi;          // single-section output pulled high
        logic dpm_off;
        logic [7:0] max_current_setting_base;
    } strap_t;

    typedef struct packed {
        logic [7:0] pmbus_addr;
        logic [3:0] svid_addr;
        logic [1:0] n_phases;
        logic single_dis;
        logic dpm_off;
        logic [9:0] max_current_setting;
    } cfg_t;
endpackage
`default_nettype wire

// [design/strap_config_phase_mgmt.sv]
// Purpose: strap-derived configuration and phase management
// Assumes: inputs synchronous to ref_clk; AXI4-Lite slave, 32-bit data
// Notes: one state struct, one always_comb, one always_ff
`default_nettype none
module strap_config_phase_mgmt #(
    parameter int ADC_W = 10,
    parameter int CUR_W = 8
) (
    input wire logic ref_clk,                        // 100 MHz clock
    input wire logic sys_rst,                        // sync reset, high
    input wire strap_cfg_pkg::strap_t strap_in,      // strap levels
    input wire logic [7:0] power_state,              // current power state
    input wire logic [7:0] load_amps,                // total load, amperes
    input wire logic load_transient,                 // transient detector
    input wire logic [3*CUR_W-1:0] phase_cur,        // per-phase currents
    input wire logic [ADC_W-1:0] imon_adc,           // monitor conversion
    input wire logic [31:0] s_axi_awaddr,            // write address
    input wire logic s_axi_awvalid,                  // aw valid
    output logic s_axi_awready,                      // aw ready
    input wire logic [31:0] s_axi_wdata,             // write data
    input wire logic [3:0] s_axi_wstrb,              // write strobes
    input wire logic s_axi_wvalid,                   // w valid
    output logic s_axi_wready,                       // w ready
    output logic [1:0] s_axi_bresp,                  // write response
    output logic s_axi_bvalid,                       // b valid
    input wire logic s_axi_bready,                   // b ready
    input wire logic [31:0] s_axi_araddr,            // read address
    input wire logic s_axi_arvalid,                  // ar valid
    output logic s_axi_arready,                      // ar ready
    output logic [31:0] s_axi_rdata,                 // read data
    output logic [1:0] s_axi_rresp,                  // read response
    output logic s_axi_rvalid,                       // r valid
    input wire logic s_axi_rready,                   // r ready
    output logic [2:0] phase_en,                     // phase_pwm_out enables
    output logic single_section_en,                  // single section enable
    output logic [7:0] pmbus_addr,                   // derived pmbus address
    output logic cfg_valid,                          // settings loaded
    output logic [CUR_W-1:0] avg_cur,                // average phase current
    output logic [3*(CUR_W+1)-1:0] phase_err         // signed deviation per phase
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        strap_cfg_pkg::cfg_state_t st;
        strap_cfg_pkg::cfg_t cfg;
        logic [2:0] phase_mask;      // available phases
        logic [2:0] phase_en;
        logic single_en;
        logic dpm_sw;                // software phase-management enable
        logic [ADC_W-1:0] output_current_report;
        logic [CUR_W-1:0] avg;
        logic [3*(CUR_W+1)-1:0] err;
        logic aw_got, w_got;
        logic [7:0] aw_addr;
        logic [31:0] wdata;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [7:0] rej_cnt;
    } state_t;

    state_t q, d;

    // pmbus address lookup from svid strap and comp resistor
    function automatic logic [7:0] pmb_addr(input logic [3:0] sv, input logic [1:0] cs);
        logic [7:0] a;
        a = strap_cfg_pkg::PMB_B3;
        if (sv == strap_cfg_pkg::SVID_ADDR_A) begin
            case (cs)
                strap_cfg_pkg::COMP_R4K99: a = strap_cfg_pkg::PMB_A0;
                strap_cfg_pkg::COMP_R14K99: a = strap_cfg_pkg::PMB_A1;
                strap_cfg_pkg::COMP_R24K99: a = strap_cfg_pkg::PMB_A2;
                default: a = strap_cfg_pkg::PMB_A3;
            endcase
        end else begin
            case (cs)
                strap_cfg_pkg::COMP_R4K99: a = strap_cfg_pkg::PMB_B0;
                strap_cfg_pkg::COMP_R14K99: a = strap_cfg_pkg::PMB_B1;
                strap_cfg_pkg::COMP_R24K99: a = strap_cfg_pkg::PMB_B2;
                default: a = strap_cfg_pkg::PMB_B3;
            endcase
        end
        return a;
    endfunction

    // thermometer mask with the n lowest phases on, gated by mask
    function automatic logic [2:0] first_n(input logic [2:0] mask, input logic [1:0] n);
        logic [2:0] r;
        r = 3'h0;
        if (n >= 2'd1) r[0] = mask[0];
        if (n >= 2'd2) r[1] = mask[1];
        if (n >= 2'd3) r[2] = mask[2];
        return r;
    endfunction

    logic [1:0] want_n;
    logic [CUR_W+1:0] cur_sum;
    logic [CUR_W+1:0] avg_w;
    logic [7:0] rd_addr;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        want_n = 2'd0;
        cur_sum = '0;
        avg_w = '0;
        rd_addr = s_axi_araddr[7:0];
        case (q.st)
            strap_cfg_pkg::ST_IDLE: begin
                d.st = strap_cfg_pkg::ST_LOAD;
            end
            strap_cfg_pkg::ST_LOAD: begin
                // sample straps on each entry to ST_LOAD (after reset or a ctrl load write)
                d.cfg.svid_addr = strap_in.svid_addr;
                d.cfg.pmbus_addr = pmb_addr(strap_in.svid_addr, strap_in.comp_sel);
                d.phase_mask = ~strap_in.phase_hi;
                d.phase_mask[0] = 1'b1;
                d.phase_mask[1] = 1'b1;
                d.phase_en = q.phase_en & d.phase_mask;
                d.cfg.n_phases = strap_in.phase_hi[2] ? 2'd2 : 2'd3;
                d.cfg.single_dis = strap_in.single_hi;
                d.cfg.dpm_off = strap_in.dpm_off;
                // limit scales with the resolved count
                d.cfg.max_current_setting = 10'(strap_in.max_current_setting_base)
                    + (strap_in.phase_hi[2] ? 10'd50 : 10'd75);
                d.st = strap_cfg_pkg::ST_RUN;
            end
            strap_cfg_pkg::ST_RUN: begin
                // phase count policy
                if (load_transient) begin
                    want_n = q.cfg.n_phases;
                end else if (power_state == strap_cfg_pkg::FULL_POWER_STATE) begin
                    want_n = (q.cfg.dpm_off || !q.dpm_sw) ? q.cfg.n_phases : 2'd2;
                end else if (q.cfg.dpm_off || !q.dpm_sw) begin
                    want_n = (load_amps >= strap_cfg_pkg::PHASE_THRESH_MA)
                        ? q.cfg.n_phases : 2'd1;
                end else begin
                    want_n = (load_amps >= strap_cfg_pkg::PHASE_THRESH_MA)
                        ? q.cfg.n_phases : 2'd1;
                end
                d.phase_en = load_transient ? q.phase_mask
                    : first_n(q.phase_mask, want_n);
                d.single_en = !q.cfg.single_dis;
                d.output_current_report = imon_adc;
                // current sharing over working phases
                for (int i = 0; i < 3; i++) begin
                    if (q.phase_mask[i]) cur_sum = cur_sum + (CUR_W+2)'(phase_cur[i*CUR_W +: CUR_W]);
                end
                avg_w = (q.cfg.n_phases == 2'd3) ? cur_sum / (CUR_W+2)'(3)
                    : cur_sum >> 1;
                d.avg = avg_w[CUR_W-1:0];
                for (int i = 0; i < 3; i++) begin
                    d.err[i*(CUR_W+1) +: (CUR_W+1)] = q.phase_mask[i]
                        ? (CUR_W+1)'({1'b0, q.avg}) - (CUR_W+1)'({1'b0, phase_cur[i*CUR_W +: CUR_W]})
                        : '0;
                end
            end
            default: d.st = strap_cfg_pkg::ST_IDLE;
        endcase

        // axi write path
        if (s_axi_awvalid && !q.aw_got && !q.bvalid) begin
            d.aw_got = 1'b1;
            d.aw_addr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && !q.w_got && !q.bvalid) begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata;
        end
        if (q.aw_got && q.w_got) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = strap_cfg_pkg::RESP_OKAY;
            case (q.aw_addr)
                strap_cfg_pkg::OFF_CTRL: begin
                    if (q.wdata[strap_cfg_pkg::CTRL_LOAD_BIT]) d.st = strap_cfg_pkg::ST_LOAD;
                    d.dpm_sw = q.wdata[strap_cfg_pkg::CTRL_DPM_BIT];
                end
                strap_cfg_pkg::OFF_CMD: begin
                    // commands to a disabled single section are rejected
                    if (q.wdata == strap_cfg_pkg::CMD_TARGET_SINGLE && q.cfg.single_dis) begin
                        d.bresp = strap_cfg_pkg::RESP_SLVERR;
                        d.rej_cnt = q.rej_cnt + 8'h01;
                    end
                end
                strap_cfg_pkg::OFF_STRAP, strap_cfg_pkg::OFF_PHASE, strap_cfg_pkg::OFF_OUTPUT_CURRENT_REPORT,
                strap_cfg_pkg::OFF_MAX_CURRENT_SETTING, strap_cfg_pkg::OFF_AVG: ;
                default: d.bresp = strap_cfg_pkg::RESP_SLVERR;
            endcase
        end
        if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;

        // axi read path
        if (s_axi_arvalid && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rresp = strap_cfg_pkg::RESP_OKAY;
            case (rd_addr)
                strap_cfg_pkg::OFF_CTRL: d.rdata = {30'h0, q.dpm_sw, 1'b0};
                strap_cfg_pkg::OFF_STRAP: d.rdata = {16'h0, q.cfg.pmbus_addr,
                    q.cfg.svid_addr, 1'b0, q.cfg.dpm_off, q.cfg.single_dis,
                    q.st == strap_cfg_pkg::ST_RUN};
                strap_cfg_pkg::OFF_PHASE: d.rdata = {24'h0, q.phase_mask, q.phase_en,
                    q.cfg.n_phases};
                strap_cfg_pkg::OFF_OUTPUT_CURRENT_REPORT: d.rdata = 32'(q.output_current_report);
                strap_cfg_pkg::OFF_MAX_CURRENT_SETTING: d.rdata = 32'(q.cfg.max_current_setting);
                strap_cfg_pkg::OFF_CMD: d.rdata = {24'h0, q.rej_cnt};
                strap_cfg_pkg::OFF_AVG: d.rdata = 32'(q.avg);
                default: begin
                    d.rdata = 32'h0;
                    d.rresp = strap_cfg_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (q.rvalid && s_axi_rready) d.rvalid = 1'b0;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q <= '0;
            q.st <= strap_cfg_pkg::ST_IDLE;
            q.dpm_sw <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // outputs from flops, readies and cfg_valid decoded from flop state
    assign s_axi_awready = !q.aw_got && !q.bvalid;
    assign s_axi_wready = !q.w_got && !q.bvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rdata = q.rdata;
    assign phase_en = q.phase_en;
    assign single_section_en = q.single_en;
    assign pmbus_addr = q.cfg.pmbus_addr;
    assign cfg_valid = (q.st == strap_cfg_pkg::ST_RUN);
    assign avg_cur = q.avg;
    assign phase_err = q.err;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_ADDR_A: assert property (@(posedge ref_clk) disable iff (sys_rst)
        q.st == strap_cfg_pkg::ST_LOAD && strap_in.svid_addr == strap_cfg_pkg::SVID_ADDR_A
        && strap_in.comp_sel == strap_cfg_pkg::COMP_OPEN |=> pmbus_addr == 8'he2)
        else $error("pmbus address wrong for strap a open");
    AST_ADDR_B: assert property (@(posedge ref_clk) disable iff (sys_rst)
        q.st == strap_cfg_pkg::ST_LOAD && strap_in.svid_addr == strap_cfg_pkg::SVID_ADDR_B
        && strap_in.comp_sel == strap_cfg_pkg::COMP_R4K99 |=> pmbus_addr == 8'hec)
        else $error("pmbus address wrong for strap b 4k99");
    AST_FULL_TWO: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cfg_valid && power_state == strap_cfg_pkg::FULL_POWER_STATE |=> phase_en[1:0] == 2'b11)
        else $error("full power ran below two phases");
    AST_LTB_ALL: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cfg_valid && load_transient |=> phase_en == q.phase_mask)
        else $error("transient did not enable all phases");
    AST_DIS_PHASE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cfg_valid && !q.phase_mask[2] |-> !phase_en[2])
        else $error("disabled phase was driven");
    AST_SINGLE_OFF: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cfg_valid && q.cfg.single_dis |=> !single_section_en)
        else $error("single section ran while strapped off");
    AST_OUTPUT_CURRENT_REPORT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cfg_valid |=> q.output_current_report == $past(imon_adc))
        else $error("current report not updated");
    AST_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cfg_valid && $past(cfg_valid) |-> $stable(q.cfg))
        else $error("strap settings changed while running");
    AST_REJECT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        q.aw_got && q.w_got && q.aw_addr == strap_cfg_pkg::OFF_CMD && q.cfg.single_dis
        && q.wdata == strap_cfg_pkg::CMD_TARGET_SINGLE
        |=> s_axi_bvalid && s_axi_bresp == strap_cfg_pkg::RESP_SLVERR)
        else $error("single section command not rejected");
endmodule
`default_nettype wire

// [bench/strap_board.sv]
// Purpose: board side of the strap pins and phase pull-ups
// Assumes: levels are set by the bench; comp is changed once without a reset, ahead of a ctrl reload
// Notes: an unused phase output is pulled up to the five volt supply
`default_nettype none
module strap_board (
    input wire logic [3:0] svid,          // strapped svid address
    input wire logic [1:0] comp,          // comp resistor choice
    input wire logic [2:0] unused,        // phases left unpopulated
    input wire logic single_off,          // single section pulled high
    input wire logic dpm_off,             // phase management strapped off
    input wire logic [7:0] max_current_setting_base,     // strapped current base
    output var strap_cfg_pkg::strap_t strap_in  // levels seen by the device
);
    timeunit 1ns;
    timeprecision 1ps;
    // pulled-up outputs read back high; the device treats only phase two as unused
    assign strap_in = {svid, comp, unused, single_off, dpm_off, max_current_setting_base};
endmodule
`default_nettype wire

// [bench/tb.sv]
// Purpose: self-checking bench for strap configuration and phase policy
// Assumes: default widths, axi4-lite slave answering per hand-over timing
// Notes: each strap set is applied through a full reset; comp open is also loaded once by a ctrl write
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, sys_rst, single_off, dpm_off, load_transient;
    logic [3:0] svid;
    logic [1:0] comp, r;
    logic [2:0] unused;
    logic [7:0] max_current_setting_base, power_state, load_amps, pa;
    logic [23:0] phase_cur;
    logic [9:0] imon_adc;
    logic [31:0] awaddr, wdata, araddr, d;
    logic awvalid, wvalid, bready, arvalid, rready;
    wire logic awready, wready, bvalid, arready, rvalid, single_section_en, cfg_valid;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [2:0] phase_en;
    wire logic [7:0] pmbus_addr, avg_cur;
    wire logic [26:0] phase_err;
    wire strap_cfg_pkg::strap_t strap_in;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    strap_board u_strap_board (.svid(svid), .comp(comp), .unused(unused),
        .single_off(single_off), .dpm_off(dpm_off), .max_current_setting_base(max_current_setting_base),
        .strap_in(strap_in));
    strap_config_phase_mgmt #(.ADC_W(10), .CUR_W(8)) u_strap_config_phase_mgmt (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .strap_in(strap_in),
        .power_state(power_state), .load_amps(load_amps),
        .load_transient(load_transient), .phase_cur(phase_cur), .imon_adc(imon_adc),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .phase_en(phase_en),
        .single_section_en(single_section_en), .pmbus_addr(pmbus_addr),
        .cfg_valid(cfg_valid), .avg_cur(avg_cur), .phase_err(phase_err));
    // ----------------------------------------------------------------
    // clock, watchdog and verdict
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // a hang counts as a mismatch
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (bad_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        awaddr <= {24'h0, a};
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (aw && awready === 1'b1) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready === 1'b1) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end while (aw || w || bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ar;
        ar = 1'b1;
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (ar && arready === 1'b1) begin
                ar = 1'b0;
                arvalid <= 1'b0;
            end
        end while (ar || rvalid !== 1'b1);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    // read, check the masked word and an okay response
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] v;
        logic [1:0] rs;
        rd(a, v, rs);
        chk(v & m, e);
        chk(32'(rs), 32'(strap_cfg_pkg::RESP_OKAY));
    endtask
    // reset, checking cfg_valid and pmbus_addr are cleared while it is held
    task automatic restart();
        sys_rst <= 1'b1;
        repeat (20) @(posedge ref_clk);
        chk({cfg_valid, pmbus_addr}, 32'h0);
        sys_rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic settle();
        repeat (3) @(posedge ref_clk);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, load_transient} = 6'h0;
        {awaddr, wdata, araddr} = '0;
        {unused, single_off, dpm_off, power_state, load_amps} = '0;
        max_current_setting_base = 8'h20;
        phase_cur = 24'h0;
        imon_adc = 10'h0;
        // every address strap and comp resistor combination
        for (int i = 0; i < 8; i++) begin
            svid <= i[2] ? strap_cfg_pkg::SVID_ADDR_B : strap_cfg_pkg::SVID_ADDR_A;
            comp <= i[1:0];
            restart();
            pa = (i[2] ? strap_cfg_pkg::PMB_B0 : strap_cfg_pkg::PMB_A0) - {i[1:0], 2'b00};
            chk(32'({cfg_valid, pmbus_addr}), {23'h0, 1'b1, pa});
            rchk(strap_cfg_pkg::OFF_STRAP, 32'hffff_ffff, {16'h0, pa, svid, 4'h1});
        end
        svid <= strap_cfg_pkg::SVID_ADDR_A;
        comp <= strap_cfg_pkg::COMP_R4K99;
        restart();
        comp <= strap_cfg_pkg::COMP_OPEN;
        settle();
        chk(32'(pmbus_addr), 32'(strap_cfg_pkg::PMB_A0));
        rchk(strap_cfg_pkg::OFF_CTRL, 32'h2, 32'h2);
        wr(strap_cfg_pkg::OFF_CTRL, 32'h3, r);
        chk(32'(r), 32'(strap_cfg_pkg::RESP_OKAY));
        rchk(strap_cfg_pkg::OFF_PHASE, 32'h3, 32'h3);
        chk(32'(pmbus_addr), 32'(strap_cfg_pkg::PMB_A3));
        rchk(strap_cfg_pkg::OFF_MAX_CURRENT_SETTING, 32'hffff_ffff, 32'h20 + 32'd75);
        for (int k = 0; k < 2; k++) begin
            imon_adc <= k ? 10'h155 : 10'h3ff;
            settle();
            rchk(strap_cfg_pkg::OFF_OUTPUT_CURRENT_REPORT, 32'hffff_ffff, k ? 32'h155 : 32'h3ff);
        end
        phase_cur <= {8'd30, 8'd20, 8'd10};
        settle();
        chk(32'(avg_cur), 32'd20);
        chk(32'(phase_err), 32'({9'h1f6, 9'h000, 9'h00a}));
        rchk(strap_cfg_pkg::OFF_AVG, 32'hff, 32'd20);
        chk(32'(single_section_en), 32'h1);
        wr(strap_cfg_pkg::OFF_CMD, strap_cfg_pkg::CMD_TARGET_SINGLE, r);
        chk(32'(r), 32'(strap_cfg_pkg::RESP_OKAY));
        power_state <= strap_cfg_pkg::FULL_POWER_STATE;
        load_amps <= strap_cfg_pkg::PHASE_THRESH_MA - 8'd1;
        settle();
        chk(32'($countones(phase_en) >= 2), 32'h1);
        wr(strap_cfg_pkg::OFF_CTRL, 32'h0, r);
        settle();
        chk(32'(phase_en), 32'h7);
        power_state <= 8'h01;
        load_transient <= 1'b1;
        settle();
        chk(32'(phase_en), 32'h7);
        rd(8'h1c, d, r);
        chk(d, 32'h0);
        chk(32'(r), 32'(strap_cfg_pkg::RESP_SLVERR));
        wr(8'h1c, 32'h1, r);
        chk(32'(r), 32'(strap_cfg_pkg::RESP_SLVERR));
        // phase two unused, single section off, phase management off
        {unused, single_off, dpm_off, load_transient} <= {3'b100, 3'b110};
        power_state <= strap_cfg_pkg::FULL_POWER_STATE;
        load_amps <= 8'd5;
        phase_cur <= {8'd0, 8'd30, 8'd10};
        restart();
        settle();
        rchk(strap_cfg_pkg::OFF_PHASE, 32'h3, 32'h2);
        rchk(strap_cfg_pkg::OFF_MAX_CURRENT_SETTING, 32'hffff_ffff, 32'h20 + 32'd50);
        rchk(strap_cfg_pkg::OFF_STRAP, 32'h7, 32'h7);
        chk(32'(phase_en), 32'h3);
        chk(32'(avg_cur), 32'd20);
        chk(32'(single_section_en), 32'h0);
        wr(strap_cfg_pkg::OFF_CMD, strap_cfg_pkg::CMD_TARGET_SINGLE, r);
        chk(32'(r), 32'(strap_cfg_pkg::RESP_SLVERR));
        rchk(strap_cfg_pkg::OFF_CMD, 32'hff, 32'h1);
        power_state <= 8'h01;
        settle();
        chk(32'($countones(phase_en)), 32'h1);
        load_transient <= 1'b1;
        settle();
        chk(32'(phase_en), 32'h3);
        finish_test();
    end
endmodule
`default_nettype wire
